// >>> cpx_pkg.sv
// Constants, opcode fields, bus map and state layout of the execute core
// Contract
// RULE1: Relative branch target is PC plus 1 plus signed 9-bit offset; two cycles.
// RULE2: Branch by accumulator target is PC plus 1 plus unsigned W; two cycles.
// RULE3: Bit test skips next instruction with a no-op cycle when bit is one.
// RULE4: Bit set forces selected bit 0..7 to one; other bits and flags untouched.
// RULE5: Call pushes PC plus 1, loads 11-bit literal, upper bits from latch 6:3.
// RULE6: Watchdog kick clears counter and prescaler, sets timeout and powerdown bits.
// RULE7: Call by accumulator pushes PC plus 1, PC becomes latch 6:0 and W.
// RULE8: Invert writes complement of file to W or file; updates zero.
// RULE9: File clear and accumulator clear write zero and set zero flag.
// RULE10: Increment and decrement write result to W or file; update zero.
// RULE11: Decrement-skip stores result, skips on zero, changes no flags.
// RULE12: Increment-skip stores result, skips on zero, changes no flags.
// RULE13: Absolute jump loads 11-bit literal and latch 6:3, no push; two cycles.
// RULE14: Literal OR puts W OR literal into W and updates zero.
// RULE15: Register OR puts W OR file into chosen destination; updates zero.
// RULE16: Left shift moves bit 7 to carry, inserts zero; updates carry, zero.
// RULE17: Right shift moves bit 0 to carry, inserts zero; updates carry, zero.
// RULE18: Copy file moves file to W or itself and updates zero.
// RULE19: Pointer load uses pointer 0 or 1 with pre/post inc/dec modifier.
// RULE20: Indexed pointer load uses pointer plus signed 6-bit offset; pointer kept.
// RULE21: Pointers wrap modulo 16 bits; pointer updates touch no flag.
// RULE22: Alias accesses go to the location held by the matching pointer.
// RULE23: Bank literal loads 5-bit value into bank select; flags unchanged.
// RULE24: Any PC change or true skip costs one extra no-op cycle.
// RULE25: Alias access with pointer MSB set costs one extra cycle.
// RULE26: Zero flag is set when the 8-bit result is zero, else cleared.
package cpx_pkg;
  localparam int PC_W = 15;
  localparam int FSR_W = 16;
  localparam int SP_W = 4;
  localparam int BADDR_W = 12;
  // Bus byte offsets
  localparam logic [11:0] OFS_INSN = 12'h000;
  localparam logic [11:0] OFS_PC = 12'h004;
  localparam logic [11:0] OFS_W = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h00C;
  localparam logic [11:0] OFS_BANK = 12'h010;
  localparam logic [11:0] OFS_PTR0 = 12'h014;
  localparam logic [11:0] OFS_PTR1 = 12'h018;
  localparam logic [11:0] OFS_RET_TOP = 12'h01C;
  localparam logic [11:0] OFS_WDOG = 12'h020;
  localparam logic [1:0] DMEM_WIN = 2'h1;
  // Status and bank word fields
  localparam int ST_C = 0;
  localparam int ST_Z = 2;
  localparam int ST_PWDN = 3;
  localparam int ST_TMOUT = 4;
  localparam int ST_BUSY = 8;
  localparam int BANK_LATCH_LSB = 8;
  // Opcode prefixes
  localparam logic [13:0] OPC_BR_ACC = 14'h000B;
  localparam logic [13:0] OPC_CALL_ACC = 14'h000A;
  localparam logic [13:0] OPC_KICK = 14'h0064;
  localparam logic [10:0] PFX_PLOAD = 11'h002;
  localparam logic [8:0] PFX_BANK = 9'h001;
  localparam logic [4:0] PFX_REL_BR = 5'h19;
  localparam logic [2:0] PFX_CALL = 3'h4;
  localparam logic [2:0] PFX_JUMP = 3'h5;
  localparam logic [3:0] PFX_BSET = 4'h5;
  localparam logic [3:0] PFX_BTSKIP = 4'h7;
  localparam logic [6:0] PFX_PINDEX = 7'h7E;
  localparam logic [5:0] PFX_INV = 6'h09;
  localparam logic [5:0] PFX_CLR = 6'h01;
  localparam logic [5:0] PFX_DEC = 6'h03;
  localparam logic [5:0] PFX_DECSK = 6'h0B;
  localparam logic [5:0] PFX_INC = 6'h0A;
  localparam logic [5:0] PFX_INCSK = 6'h0F;
  localparam logic [5:0] PFX_ORF = 6'h04;
  localparam logic [5:0] PFX_COPY = 6'h08;
  localparam logic [5:0] PFX_SHL = 6'h35;
  localparam logic [5:0] PFX_SHR = 6'h36;
  localparam logic [5:0] PFX_ORL = 6'h38;
  localparam logic [6:0] F_ALIAS0 = 7'h00;
  localparam logic [6:0] F_ALIAS1 = 7'h01;
  localparam logic [1:0] PMOD_PREINC = 2'h0;
  localparam logic [1:0] PMOD_PREDEC = 2'h1;
  localparam logic [1:0] PMOD_POSTINC = 2'h2;

  typedef enum logic [1:0] {CORE_IDLE, CORE_EXEC, CORE_EXTRA} cpx_core_e;
  typedef enum logic {BUS_IDLE, BUS_WAIT} cpx_bus_e;
  typedef enum logic [4:0] {
    no_operation_op, relative_branch_op, branch_by_accum_op, test_skip_if_one_op,
    set_file_bit_op, subroutine_call_op, subroutine_by_accum_op, watchdog_kick_op,
    invert_file_op, zero_file_op, zero_accum_op, minus_one_op, minus_one_skip_op,
    absolute_jump_op, plus_one_skip_op, plus_one_op, or_literal_op, or_file_op,
    shift_left_logic_op, shift_right_logic_op, copy_file_op, pointer_load_accum_op,
    pointer_index_accum_op, bank_literal_op
  } cpx_op_e;

  typedef struct packed {
    cpx_core_e core;
    cpx_bus_e bus;
    logic [13:0] ir;
    logic [PC_W-1:0] pc;
    logic [7:0] w;
    logic carry;
    logic zero;
    logic timeout_status_bit;
    logic powerdown_status_bit;
    logic [4:0] bank_selection_reg;
    logic [6:0] pc_page_latch;
    logic [1:0][FSR_W-1:0] indirect_pointer_pair;
    logic [SP_W-1:0] sp;
    logic [1:0] extra;
    logic [7:0] watchdog_counter;
    logic [7:0] wdog_pre;
    logic [BADDR_W-1:0] b_addr;
    logic b_map;
    logic b_write;
    logic hready;
    logic resp;
    logic [31:0] hrdata;
  } cpx_state_s;

  localparam cpx_state_s STATE_RST = '{core: CORE_IDLE, bus: BUS_IDLE, hready: 1'b1,
    timeout_status_bit: 1'b1, powerdown_status_bit: 1'b1, default: '0};
endpackage : cpx_pkg

// >>> cpx_core.sv
// Instruction execute core with AHB-Lite register and data memory access
//
// Register access over AHB-Lite and the placing of the registers were decided locally.
`timescale 1ns/10ps
module cpx_core import cpx_pkg::*; #(
  parameter int DMEM_AW = 8,
  parameter int STACK_DEPTH = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);
  if (DMEM_AW < 2 || DMEM_AW > 8) begin : g_bad_aw
    $error("DMEM_AW must lie in 2..8");
  end
  if (STACK_DEPTH < 2 || STACK_DEPTH > (1 << SP_W)) begin : g_bad_sd
    $error("STACK_DEPTH must lie in 2..16");
  end

  cpx_state_s s_reg;
  cpx_state_s s_next;
  logic [7:0] dmem [0:(1 << DMEM_AW)-1];
  logic [PC_W-1:0] stack [0:STACK_DEPTH-1];

  cpx_op_e op;
  logic ex;
  logic ptr_sel;
  logic [FSR_W-1:0] ptr;
  logic [FSR_W-1:0] ptr_new;
  logic [FSR_W-1:0] ea;
  logic [11:0] direct;
  logic alias_hit;
  logic ind_x;
  logic [DMEM_AW-1:0] dm_addr;
  logic [7:0] rd;
  logic [7:0] res;
  logic [7:0] bmask;
  logic [PC_W-1:0] pc1;
  logic [PC_W-1:0] npc;
  logic pc_mod;
  logic skip;
  logic z_upd;
  logic to_dest;
  logic mem_we;
  logic [DMEM_AW-1:0] mem_addr;
  logic [7:0] mem_wd;
  logic st_push;
  logic [SP_W-1:0] sp_inc;
  logic [DMEM_AW-1:0] b_idx;
  logic capture;

  function automatic cpx_op_e decode_op(input logic [13:0] ir);
    cpx_op_e o;
    o = no_operation_op;
    if (ir == OPC_BR_ACC) o = branch_by_accum_op;
    else if (ir == OPC_CALL_ACC) o = subroutine_by_accum_op;
    else if (ir == OPC_KICK) o = watchdog_kick_op;
    else if (ir[13:3] == PFX_PLOAD) o = pointer_load_accum_op;
    else if (ir[13:5] == PFX_BANK) o = bank_literal_op;
    else if (ir[13:9] == PFX_REL_BR) o = relative_branch_op;
    else if (ir[13:11] == PFX_CALL) o = subroutine_call_op;
    else if (ir[13:11] == PFX_JUMP) o = absolute_jump_op;
    else if (ir[13:10] == PFX_BSET) o = set_file_bit_op;
    else if (ir[13:10] == PFX_BTSKIP) o = test_skip_if_one_op;
    else if (ir[13:7] == PFX_PINDEX) o = pointer_index_accum_op;
    else begin
      case (ir[13:8])
        PFX_INV: o = invert_file_op;
        PFX_CLR: o = ir[7] ? zero_file_op : zero_accum_op;
        PFX_DEC: o = minus_one_op;
        PFX_DECSK: o = minus_one_skip_op;
        PFX_INC: o = plus_one_op;
        PFX_INCSK: o = plus_one_skip_op;
        PFX_ORF: o = or_file_op;
        PFX_COPY: o = copy_file_op;
        PFX_SHL: o = shift_left_logic_op;
        PFX_SHR: o = shift_right_logic_op;
        PFX_ORL: o = or_literal_op;
        default: o = no_operation_op;
      endcase
    end
    return o;
  endfunction : decode_op

  assign capture = hsel && hready && htrans[1];
  assign b_idx = s_reg.b_addr[DMEM_AW+1:2];

  always_comb begin
    s_next = s_reg;
    op = decode_op(s_reg.ir);
    ex = (s_reg.core == CORE_EXEC);
    res = 8'h00;
    pc_mod = 1'b0;
    skip = 1'b0;
    z_upd = 1'b0;
    to_dest = 1'b0;
    mem_we = 1'b0;
    mem_wd = 8'h00;
    st_push = 1'b0;
    pc1 = s_reg.pc + PC_W'(1);
    npc = pc1;
    sp_inc = (s_reg.sp == SP_W'(STACK_DEPTH - 1)) ? '0 : s_reg.sp + SP_W'(1);
    bmask = 8'h01 << s_reg.ir[9:7];
    // Alias and pointer addressing
    if (op == pointer_load_accum_op) ptr_sel = s_reg.ir[2];
    else if (op == pointer_index_accum_op) ptr_sel = s_reg.ir[6];
    else ptr_sel = s_reg.ir[0];
    ptr = s_reg.indirect_pointer_pair[ptr_sel];
    ptr_new = ptr;
    ea = ptr;
    if (op == pointer_load_accum_op) begin
      case (s_reg.ir[1:0]) // [RULE19] [RULE21]
        PMOD_PREINC: begin
          ptr_new = ptr + FSR_W'(1);
          ea = ptr_new;
        end
        PMOD_PREDEC: begin
          ptr_new = ptr - FSR_W'(1);
          ea = ptr_new;
        end
        PMOD_POSTINC: ptr_new = ptr + FSR_W'(1);
        default: ptr_new = ptr - FSR_W'(1);
      endcase
    end else if (op == pointer_index_accum_op) begin
      ea = ptr + {{10{s_reg.ir[5]}}, s_reg.ir[5:0]}; // [RULE20]
    end
    alias_hit = (op == pointer_load_accum_op) || (op == pointer_index_accum_op) ||
      ((op inside {set_file_bit_op, test_skip_if_one_op, invert_file_op, zero_file_op,
      minus_one_op, minus_one_skip_op, plus_one_op, plus_one_skip_op, or_file_op,
      shift_left_logic_op, shift_right_logic_op, copy_file_op}) &&
      (s_reg.ir[6:0] == F_ALIAS0 || s_reg.ir[6:0] == F_ALIAS1));
    ind_x = alias_hit && ptr[FSR_W-1]; // [RULE25]
    direct = {s_reg.bank_selection_reg, s_reg.ir[6:0]};
    // Aliases hold no storage; the pointer value is the address
    dm_addr = alias_hit ? ea[DMEM_AW-1:0] : direct[DMEM_AW-1:0]; // [RULE22]
    mem_addr = dm_addr;
    rd = dmem[dm_addr];

    // Free-running watchdog; its expiry lies outside this core
    s_next.wdog_pre = s_reg.wdog_pre + 8'h01;
    if (s_reg.wdog_pre == 8'hFF) s_next.watchdog_counter = s_reg.watchdog_counter + 8'h01;

    case (s_reg.core)
      CORE_EXEC: begin
        case (op)
          relative_branch_op: begin
            npc = pc1 + {{6{s_reg.ir[8]}}, s_reg.ir[8:0]}; // [RULE1]
            pc_mod = 1'b1;
          end
          branch_by_accum_op: begin
            npc = pc1 + {7'h00, s_reg.w}; // [RULE2]
            pc_mod = 1'b1;
          end
          subroutine_call_op: begin
            st_push = 1'b1;
            npc = {s_reg.pc_page_latch[6:3], s_reg.ir[10:0]}; // [RULE5]
            pc_mod = 1'b1;
          end
          subroutine_by_accum_op: begin
            st_push = 1'b1;
            npc = {s_reg.pc_page_latch, s_reg.w}; // [RULE7]
            pc_mod = 1'b1;
          end
          absolute_jump_op: begin
            npc = {s_reg.pc_page_latch[6:3], s_reg.ir[10:0]}; // [RULE13]
            pc_mod = 1'b1;
          end
          test_skip_if_one_op: skip = rd[s_reg.ir[9:7]]; // [RULE3]
          set_file_bit_op: begin
            mem_we = 1'b1;
            mem_wd = rd | bmask; // [RULE4]
          end
          watchdog_kick_op: begin
            s_next.watchdog_counter = 8'h00; // [RULE6]
            s_next.wdog_pre = 8'h00;
            s_next.timeout_status_bit = 1'b1;
            s_next.powerdown_status_bit = 1'b1;
          end
          invert_file_op: begin
            res = ~rd; // [RULE8]
            to_dest = 1'b1;
            z_upd = 1'b1;
          end
          zero_file_op: begin
            mem_we = 1'b1; // [RULE9]
            z_upd = 1'b1;
          end
          zero_accum_op: begin
            s_next.w = 8'h00; // [RULE9]
            z_upd = 1'b1;
          end
          minus_one_op, plus_one_op: begin
            res = (op == plus_one_op) ? rd + 8'h01 : rd - 8'h01; // [RULE10]
            to_dest = 1'b1;
            z_upd = 1'b1;
          end
          minus_one_skip_op, plus_one_skip_op: begin
            // Flags stay put; only the skip reacts to the result
            res = (op == plus_one_skip_op) ? rd + 8'h01 : rd - 8'h01; // [RULE11] [RULE12]
            to_dest = 1'b1;
            skip = (res == 8'h00);
          end
          or_literal_op: begin
            res = s_reg.w | s_reg.ir[7:0]; // [RULE14]
            s_next.w = res;
            z_upd = 1'b1;
          end
          or_file_op: begin
            res = s_reg.w | rd; // [RULE15]
            to_dest = 1'b1;
            z_upd = 1'b1;
          end
          shift_left_logic_op: begin
            res = {rd[6:0], 1'b0}; // [RULE16]
            s_next.carry = rd[7];
            to_dest = 1'b1;
            z_upd = 1'b1;
          end
          shift_right_logic_op: begin
            res = {1'b0, rd[7:1]}; // [RULE17]
            s_next.carry = rd[0];
            to_dest = 1'b1;
            z_upd = 1'b1;
          end
          copy_file_op: begin
            res = rd; // [RULE18]
            to_dest = 1'b1;
            z_upd = 1'b1;
          end
          pointer_load_accum_op, pointer_index_accum_op: begin
            res = rd; // [RULE19]
            s_next.w = res;
            s_next.indirect_pointer_pair[ptr_sel] = ptr_new; // [RULE21]
            z_upd = 1'b1;
          end
          bank_literal_op: s_next.bank_selection_reg = s_reg.ir[4:0]; // [RULE23]
          default: ;
        endcase
        if (to_dest) begin
          if (s_reg.ir[7]) begin
            mem_we = 1'b1;
            mem_wd = res;
          end else begin
            s_next.w = res;
          end
        end
        if (z_upd) s_next.zero = (res == 8'h00); // [RULE26]
        if (skip) npc = pc1 + PC_W'(1);
        if (st_push) s_next.sp = sp_inc;
        s_next.pc = npc;
        // No-op cycle for a PC change or skip, one more for a high alias pointer
        s_next.extra = {1'b0, pc_mod || skip} + {1'b0, ind_x}; // [RULE24] [RULE25]
        s_next.core = (s_next.extra != 2'h0) ? CORE_EXTRA : CORE_IDLE;
      end
      CORE_EXTRA: begin
        s_next.extra = s_reg.extra - 2'h1;
        if (s_reg.extra == 2'h1) s_next.core = CORE_IDLE;
      end
      default: ;
    endcase

    // Bus slave: each access waits in its data phase until the core is idle
    case (s_reg.bus)
      BUS_IDLE: begin
        if (capture) begin
          s_next.b_addr = haddr[BADDR_W-1:0];
          s_next.b_map = (haddr[31:BADDR_W] == 20'h00000);
          s_next.b_write = hwrite;
          s_next.hready = 1'b0;
          s_next.bus = BUS_WAIT;
        end
      end
      BUS_WAIT: begin
        if (s_reg.core == CORE_IDLE) begin
          s_next.hready = 1'b1;
          s_next.bus = BUS_IDLE;
          s_next.hrdata = 32'h00000000;
          if (s_reg.b_map && s_reg.b_addr[11:10] == DMEM_WIN) begin
            s_next.hrdata = {24'h000000, dmem[b_idx]};
            if (s_reg.b_write) begin
              mem_we = 1'b1;
              mem_addr = b_idx;
              mem_wd = hwdata[7:0];
            end
          end else if (s_reg.b_map) begin
            case (s_reg.b_addr)
              OFS_INSN: begin
                s_next.hrdata = {18'h00000, s_reg.ir};
                if (s_reg.b_write) begin
                  s_next.ir = hwdata[13:0];
                  s_next.core = CORE_EXEC;
                end
              end
              OFS_PC: begin
                s_next.hrdata = {17'h00000, s_reg.pc};
                if (s_reg.b_write) s_next.pc = hwdata[PC_W-1:0];
              end
              OFS_W: begin
                s_next.hrdata = {24'h000000, s_reg.w};
                if (s_reg.b_write) s_next.w = hwdata[7:0];
              end
              OFS_STATUS: begin
                s_next.hrdata[ST_C] = s_reg.carry;
                s_next.hrdata[ST_Z] = s_reg.zero;
                s_next.hrdata[ST_PWDN] = s_reg.powerdown_status_bit;
                s_next.hrdata[ST_TMOUT] = s_reg.timeout_status_bit;
                if (s_reg.b_write) begin
                  s_next.carry = hwdata[ST_C];
                  s_next.zero = hwdata[ST_Z];
                end
              end
              OFS_BANK: begin
                s_next.hrdata = {17'h00000, s_reg.pc_page_latch, 3'h0,
                  s_reg.bank_selection_reg};
                if (s_reg.b_write) begin
                  s_next.pc_page_latch = hwdata[BANK_LATCH_LSB+6:BANK_LATCH_LSB];
                  s_next.bank_selection_reg = hwdata[4:0];
                end
              end
              OFS_PTR0, OFS_PTR1: begin
                s_next.hrdata = {16'h0000, s_reg.indirect_pointer_pair[s_reg.b_addr[3]]};
                if (s_reg.b_write) begin
                  s_next.indirect_pointer_pair[s_reg.b_addr[3]] = hwdata[FSR_W-1:0];
                end
              end
              OFS_RET_TOP: s_next.hrdata = {17'h00000, stack[s_reg.sp == '0 ?
                SP_W'(STACK_DEPTH - 1) : s_reg.sp - SP_W'(1)]};
              OFS_WDOG: s_next.hrdata = {16'h0000, s_reg.watchdog_counter, s_reg.wdog_pre};
              default: ;
            endcase
          end
        end
      end
      default: ;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= STATE_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // Storage arrays carry no reset, which keeps them mappable to RAM
  always_ff @(posedge hclk) begin
    if (mem_we) dmem[mem_addr] <= mem_wd;
    if (st_push) stack[s_reg.sp] <= pc1; // [RULE5] [RULE7]
  end

  assign hreadyout = s_reg.hready;
  assign hresp = s_reg.resp;
  assign hrdata = s_reg.hrdata;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_rel_target: assert property (ex && op == relative_branch_op |=> // [RULE1]
    s_reg.pc == $past(pc1 + {{6{s_reg.ir[8]}}, s_reg.ir[8:0]}))
    else $error("relative branch target wrong");
  a_acc_target: assert property (ex && op == branch_by_accum_op |=> // [RULE2]
    s_reg.pc == $past(pc1 + {7'h00, s_reg.w}))
    else $error("accumulator branch target wrong");
  a_skip_one: assert property (ex && op == test_skip_if_one_op && !ind_x && // [RULE3]
    rd[s_reg.ir[9:7]] |=> s_reg.core == CORE_EXTRA ##1 s_reg.core == CORE_IDLE)
    else $error("bit test skip timing wrong");
  a_bit_set: assert property (ex && op == set_file_bit_op |=> // [RULE4]
    dmem[$past(dm_addr)] == ($past(rd) | $past(bmask)) && $stable(s_reg.zero))
    else $error("bit set result wrong");
  a_call_push: assert property (ex && op == subroutine_call_op |=> // [RULE5]
    stack[$past(s_reg.sp)] == $past(pc1) && s_reg.pc[10:0] == $past(s_reg.ir[10:0]))
    else $error("call push or target wrong");
  a_kick_clear: assert property (ex && op == watchdog_kick_op |=> // [RULE6]
    s_reg.watchdog_counter == 8'h00 && s_reg.timeout_status_bit && s_reg.powerdown_status_bit)
    else $error("watchdog kick effects wrong");
  a_call_acc_pc: assert property (ex && op == subroutine_by_accum_op |=> // [RULE7]
    s_reg.pc == $past({s_reg.pc_page_latch, s_reg.w}))
    else $error("accumulator call target wrong");
  a_clear_zero: assert property (ex && (op == zero_file_op || op == zero_accum_op) |=> // [RULE9]
    s_reg.zero)
    else $error("clear did not set zero");
  a_skip_flags: assert property (ex && (op == minus_one_skip_op || // [RULE11]
    op == plus_one_skip_op) |=> $stable(s_reg.zero) && $stable(s_reg.carry))
    else $error("skip op changed flags");
  a_jump_nopush: assert property (ex && op == absolute_jump_op |=> // [RULE13]
    $stable(s_reg.sp) && s_reg.pc[PC_W-1:11] == $past(s_reg.pc_page_latch[6:3]))
    else $error("jump pushed or wrong page");
  a_shl_carry: assert property (ex && op == shift_left_logic_op |=> // [RULE16]
    s_reg.carry == $past(rd[7]))
    else $error("left shift carry wrong");
  a_ptr_index: assert property (ex && op == pointer_index_accum_op |=> // [RULE20]
    s_reg.indirect_pointer_pair == $past(s_reg.indirect_pointer_pair))
    else $error("indexed load moved pointer");
  a_alias_extra: assert property (ex && ind_x && !pc_mod && !skip |=> // [RULE25]
    s_reg.core == CORE_EXTRA ##1 s_reg.core == CORE_IDLE)
    else $error("alias extra cycle missing");
  a_zero_flag: assert property (ex && z_upd |=> s_reg.zero == ($past(res) == 8'h00)) // [RULE26]
    else $error("zero flag wrong");

  c_branch: cover property (ex && op == relative_branch_op ##2 s_reg.core == CORE_IDLE);
  c_skip: cover property (ex && skip);
  c_alias_slow: cover property (ex && ind_x && pc_mod);
  c_bus_stall: cover property (!s_reg.hready [*3] ##1 s_reg.hready);
endmodule : cpx_core

// >>> cpx_host.sv
// Bus master model standing in for software on the register bus
`timescale 1ns/10ps
module cpx_host (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel = 1'b0,
  output logic [31:0] haddr = 32'h0,
  output logic [1:0] htrans = 2'h0,
  output logic hwrite = 1'b0,
  output logic [2:0] hsize = 3'h2,
  output logic [31:0] hwdata = 32'h0
);
  // Each phase is held until hready is seen high; a stuck slave gives up after 50 edges
  task automatic xfer(input logic [11:0] a, input logic wr, input logic [15:0] d,
                      output logic [31:0] q, output logic ok);
    int n;
    int m;
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    for (n = 0; n < 50; n++) begin
      @(posedge hclk);
      if (hready === 1'b1) break;
    end
    htrans <= 2'h0;
    hwdata <= {16'h0, d};
    for (m = 0; m < 50; m++) begin
      @(posedge hclk);
      if (hready === 1'b1) break;
    end
    q = hrdata;
    // Stale write data is inverted so nothing can lean on it
    hwdata <= ~{16'h0, d};
    ok = (n < 50) && (m < 50);
  endtask : xfer
endmodule : cpx_host

// >>> cpx_core_tb.sv
// Self-checking bench for the instruction execute core
`timescale 1ns/10ps
module cpx_core_tb import cpx_pkg::*;;
  typedef struct packed {
    logic [15:0] op, s0, w0, f0, s, w, f, pc;
  } cpx_row_s;
  localparam logic [11:0] FILE_A = 12'h480;
  logic hclk, hresetn, hsel, hwrite, hready, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int fails = 0;
  int samples_checked = 0;
  cpx_row_s r;
  // Op, status in, W in, file in, status out, W out, file out, PC out; PC starts at 0x10
  cpx_row_s rows [20] = '{
    128'h09A0_0004_0000_005A_0018_0000_00A5_0011,
    128'h01A0_0000_0012_0033_001C_0012_0000_0011,
    128'h0100_0000_0012_0033_001C_0000_0033_0011,
    128'h03A0_0000_0000_0001_001C_0000_0000_0011,
    128'h0A20_0004_0000_007F_0018_0080_007F_0011,
    128'h0BA0_0000_0000_0001_0018_0000_0000_0012,
    128'h0B20_0005_0000_0005_001D_0004_0005_0011,
    128'h0F20_0000_0033_00FF_0018_0000_00FF_0012,
    128'h04A0_0004_000F_00F0_0018_000F_00FF_0011,
    128'h3800_0000_0000_0011_001C_0000_0011_0011,
    128'h35A0_0000_0000_0081_0019_0000_0002_0011,
    128'h3620_0000_0055_0001_001D_0000_0001_0011,
    128'h0820_0000_0055_0000_001C_0000_0000_0011,
    128'h17A0_0005_0000_0001_001D_0000_0081_0011,
    128'h1C20_0000_0000_0001_0018_0000_0001_0012,
    128'h1C20_0000_0000_00FE_0018_0000_00FE_0011,
    128'h32FF_0000_0000_0000_0018_0000_0000_0110,
    128'h000B_0000_00FF_0000_0018_00FF_0000_0110,
    128'h27FF_0000_0000_0000_0018_0000_0000_2FFF,
    128'h2801_0000_0000_0000_0018_0000_0000_2801
  };
  cpx_core cpx_core_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata));
  cpx_host cpx_host_inst (.hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  task automatic results;
    if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic [31:0] q;
    logic ok;
    cpx_host_inst.xfer(a, 1'b1, d, q, ok);
    if (!ok) begin
      fails++;
      $display("wrong value at %0t: write to %h timed out", $time, a);
      results();
    end
  endtask : wr
  // Upper halfword is always compared, so stray high bits are caught
  task automatic rd(input logic [11:0] a, input logic [15:0] e, input logic [15:0] m = 16'hFFFF);
    logic [31:0] q;
    logic ok;
    cpx_host_inst.xfer(a, 1'b0, 16'h0, q, ok);
    if (!ok) begin
      fails++;
      $display("wrong value at %0t: read of %h timed out", $time, a);
      results();
    end
    samples_checked++;
    // The response must always be OKAY as well
    if ((q & {16'hFFFF, m}) !== {16'h0, e} || hresp !== 1'b0) begin
      fails++;
      $display("wrong value at %0t: addr %h read %h want %h resp %b", $time, a, q, e, hresp);
    end
  endtask : rd
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  initial begin
    hresetn = 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(OFS_STATUS, 16'h0018);
    rd(OFS_PC, 16'h0000);
    for (int i = 0; i < 20; i++) begin
      r = rows[i];
      wr(OFS_BANK, 16'h2800);
      wr(OFS_PC, 16'h0010);
      wr(OFS_W, r.w0);
      wr(OFS_STATUS, r.s0);
      wr(FILE_A, r.f0);
      wr(OFS_INSN, r.op);
      rd(OFS_W, r.w);
      rd(OFS_STATUS, r.s);
      rd(FILE_A, r.f);
      rd(OFS_PC, r.pc);
    end
    wr(OFS_PC, 16'h0040);
    wr(OFS_W, 16'h0034);
    wr(OFS_INSN, 16'h000A);
    rd(OFS_PC, 16'h2834);
    rd(OFS_RET_TOP, 16'h0041);
    wr(OFS_INSN, 16'h2801);
    rd(OFS_RET_TOP, 16'h0041);
    wr(OFS_INSN, 16'h003F);
    rd(OFS_BANK, 16'h281F);
    wr(12'h024, 16'hFFFF);
    rd(12'h024, 16'h0000);
    wr(12'h400, 16'h0066);
    wr(OFS_PTR0, 16'hFFFF);
    wr(OFS_W, 16'h0000);
    wr(OFS_INSN, 16'h0010);
    rd(OFS_W, 16'h0066);
    rd(OFS_PTR0, 16'h0000);
    wr(OFS_W, 16'h0000);
    wr(OFS_PTR1, 16'h0010);
    wr(OFS_INSN, 16'h3F70);
    rd(OFS_W, 16'h0066);
    rd(OFS_PTR1, 16'h0010);
    wr(12'h400, 16'h0000);
    wr(OFS_INSN, 16'h0013);
    rd(OFS_STATUS, 16'h0004, 16'h0004);
    rd(OFS_PTR0, 16'hFFFF);
    wr(12'h7FC, 16'h0041);
    wr(OFS_INSN, 16'h0A80);
    rd(12'h7FC, 16'h0042);
    // Post-increment and pre-decrement across the pointer's wrap point
    wr(OFS_W, 16'h0000);
    wr(OFS_INSN, 16'h0012);
    rd(OFS_W, 16'h0042);
    rd(OFS_PTR0, 16'h0000);
    wr(OFS_W, 16'h0000);
    wr(OFS_INSN, 16'h0011);
    rd(OFS_W, 16'h0042);
    rd(OFS_PTR0, 16'hFFFF);
    // Long idle so the counter has moved well off zero before the kick
    repeat (600) @(posedge hclk);
    wr(OFS_INSN, 16'h0064);
    rd(OFS_WDOG, 16'h0000, 16'hFF00);
    rd(OFS_STATUS, 16'h0018, 16'h0018);
    results();
  end
endmodule : cpx_core_tb
